/* dv/mgmt_ctrl_model.sv */
`timescale 1ns/100ps
module mgmt_ctrl_model (
   input wire logic i_clock,
   input wire logic i_cmd_ready,
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_byte,
   input wire logic i_rsp_last,
   output logic o_cmd_valid,
   output prr_pkg::cmd_t o_cmd,
   output logic o_rsp_ready
);
   logic [7:0] got [$];
   int last_at;
   logic slow;

   initial
   begin
      o_cmd_valid = 1'b0;
      o_cmd = '0;
      o_rsp_ready = 1'b1;
      slow = 1'b0;
      last_at = 0;
   end

   // the query itself carries no payload, only the type code and check outcome
   task automatic send_cmd(input logic [7:0] kind, input logic ce, input logic idm);
      int n;
      n = 0;
      @(posedge i_clock);
      #1;
      o_cmd_valid = 1'b1;
      o_cmd = '{kind, ce, idm};
      while (i_cmd_ready !== 1'b1 && n < 200)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      @(posedge i_clock);
      #1;
      o_cmd_valid = 1'b0;
      // released command lines must not keep showing the old value
      o_cmd = ~o_cmd;
   endtask

   // a stalling sink alternates ready so holds are exercised
   always @(posedge i_clock)
   begin
      #1;
      o_rsp_ready = slow ? ~o_rsp_ready : 1'b1;
   end

   // a byte is taken at the rising edge where valid and ready both stand
   always @(posedge i_clock)
   begin
      if (i_rsp_valid === 1'b1 && o_rsp_ready === 1'b1)
      begin
         got.push_back(i_rsp_byte);
         if (i_rsp_last === 1'b1)
         begin
            last_at = got.size();
         end
      end
   end
endmodule

/* dv/parameter_report_responder_bench.sv */
`timescale 1ns/100ps
module parameter_report_responder_bench;
   logic i_clock;
   logic i_arst_n;
   prr_pkg::cfg_t cfg;
   prr_pkg::cmd_t cmd;
   prr_pkg::cap_t cap;
   logic mac_we, tag_we, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready;
   logic [2:0] mac_idx;
   logic [3:0] tag_idx;
   logic [47:0] mac_value;
   logic [15:0] tag_value;
   logic [7:0] cap_type, rsp_byte, rsp_type, rsp_end;
   logic [47:0] macs [8];
   logic [15:0] tags [15];
   logic [7:0] exp_q [$];
   int miscompares, tests_run, cycles;
   logic [7:0] bad_kind [3] = '{8'h18, 8'h17, 8'h17};
   logic bad_ce [3] = '{1'b0, 1'b1, 1'b0};
   logic bad_id [3] = '{1'b0, 1'b0, 1'b1};

   parameter_report_responder parameter_report_responder_inst (.i_clock(i_clock),
      .i_arst_n(i_arst_n), .i_cfg(cfg), .i_mac_we(mac_we), .i_mac_idx(mac_idx),
      .i_mac_value(mac_value), .i_tag_we(tag_we), .i_tag_idx(tag_idx), .i_tag_value(tag_value),
      .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready), .o_cap(cap),
      .o_cap_type(cap_type), .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte),
      .o_rsp_last(rsp_last), .o_rsp_type(rsp_type), .o_rsp_end(rsp_end),
      .i_rsp_ready(rsp_ready));

   mgmt_ctrl_model mgmt_ctrl_model_inst (.i_clock(i_clock), .i_cmd_ready(cmd_ready),
      .i_rsp_valid(rsp_valid), .i_rsp_byte(rsp_byte), .i_rsp_last(rsp_last),
      .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_rsp_ready(rsp_ready));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic load(input logic [7:0] s);
      @(posedge i_clock);
      #1;
      cfg = '{8'hA5 ^ s, {7'h55, s}, {4{s}}, {s, 24'h123456}, s[3:0], s, ~s, {s, 24'hABCDEF}};
      for (int i = 0; i < 15; i++)
      begin
         // only the first eight entries reach the store, so only they are expected
         if (i < 8)
         begin
            macs[i] = {6{s}} ^ 48'(i);
         end
         tags[i] = {s, 8'h00} | 16'(i);
         mac_we = i < 8;
         mac_idx = 3'(i);
         mac_value = macs[i % 8];
         tag_we = 1'b1;
         tag_idx = 4'(i);
         tag_value = tags[i];
         @(posedge i_clock);
         #1;
      end
      mac_we = 1'b0;
      tag_we = 1'b0;
   endtask

   task automatic push_word(input logic [31:0] w);
      for (int b = 3; b >= 0; b--)
      begin
         exp_q.push_back(w[b*8 +: 8]);
      end
   endtask

   task automatic run_query(input logic slow);
      int n;
      exp_q = {};
      push_word(32'h0);
      push_word({8'h08, 16'h0, cfg.mac_en});
      push_word({8'h0F, 8'h00, 1'b0, cfg.vlan_en});
      push_word(cfg.link);
      push_word(cfg.bcast);
      push_word({28'h0, cfg.flags});
      push_word({cfg.vlan_mode, cfg.flow_ctrl, 16'h0});
      push_word(cfg.aen);
      for (int i = 0; i < 8; i++)
      begin
         for (int b = 5; b >= 0; b--)
         begin
            exp_q.push_back(macs[i][b*8 +: 8]);
         end
      end
      for (int i = 0; i < 15; i++)
      begin
         exp_q.push_back(tags[i][15:8]);
         exp_q.push_back(tags[i][7:0]);
      end
      while (exp_q.size() % 4 != 0)
      begin
         exp_q.push_back(8'h00);
      end
      mgmt_ctrl_model_inst.slow = slow;
      mgmt_ctrl_model_inst.got = {};
      mgmt_ctrl_model_inst.last_at = 0;
      mgmt_ctrl_model_inst.send_cmd(8'h17, 1'b0, 1'b0);
      n = 0;
      while (mgmt_ctrl_model_inst.got.size() < exp_q.size() && n < 1000)
      begin
         @(posedge i_clock);
         n++;
      end
      repeat (4) @(posedge i_clock);
      check(mgmt_ctrl_model_inst.got.size(), exp_q.size());
      check(mgmt_ctrl_model_inst.last_at, exp_q.size());
      check(rsp_end, exp_q.size() + 16);
      for (int i = 0; i < 32; i++)
      begin
         check(mgmt_ctrl_model_inst.got[i], exp_q[i]);
      end
      for (int i = 32; i < exp_q.size(); i++)
      begin
         check(mgmt_ctrl_model_inst.got[i], exp_q[i]);
      end
      check(cmd_ready, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         final_report();
      end
   end

   initial
   begin
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      i_arst_n = 1'b0;
      cfg = '0;
      mac_we = 1'b0;
      mac_idx = 3'h0;
      mac_value = 48'h0;
      tag_we = 1'b0;
      tag_idx = 4'h0;
      tag_value = 16'h0;
      repeat (5) @(posedge i_clock);
      #1;
      i_arst_n = 1'b1;
      check(cap.filt_counts, {8'h0F, 8'h02, 8'h02, 8'h04});
      check(cap.mode_chan, {16'h0, 8'h03, 8'h01});
      check(cap_type, 8'h96);
      check(rsp_type, 8'h97);
      load(8'h3C);
      // wrong type code and the two error flags must all be dropped silently
      for (int k = 0; k < 3; k++)
      begin
         mgmt_ctrl_model_inst.got = {};
         mgmt_ctrl_model_inst.send_cmd(bad_kind[k], bad_ce[k], bad_id[k]);
         repeat (20) @(posedge i_clock);
         check(mgmt_ctrl_model_inst.got.size(), 0);
      end
      run_query(1'b0);
      run_query(1'b1);
      load(8'hC3);
      run_query(1'b1);
      run_query(1'b0);
      final_report();
   end
endmodule

/* logic/entry_store.sv */
`timescale 1ns/100ps
module entry_store #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic i_re,
   input wire logic [AW-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   // contents have no reset: unwritten entries read back undefined, and their enable bits come from the configuration alone
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_r;

   always_ff @(posedge i_clock)
   begin
      if (i_we && (int'(i_waddr) < DEPTH))
      begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rdata_r <= '0;
      end
      else if (i_re)
      begin
         rdata_r <= (int'(i_raddr) < DEPTH) ? mem[i_raddr] : '0;
      end
   end

   assign o_rdata = rdata_r;
endmodule

/* logic/parameter_report_responder.sv */
`timescale 1ns/100ps
`include "prr_defs.svh"
module parameter_report_responder #(
   parameter int UNICAST_CNT = 4,
   parameter int MULTICAST_CNT = 2,
   parameter int MIXED_CNT = 2,
   parameter int VLAN_CNT = 15,
   parameter int CHANNEL_CNT = 1,
   parameter bit VLAN_PLUS_NON = 1'b1,
   parameter bit ANY_VLAN_PLUS_NON = 1'b0
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire prr_pkg::cfg_t i_cfg,
   input wire logic i_mac_we,
   input wire logic [2:0] i_mac_idx,
   input wire logic [47:0] i_mac_value,
   input wire logic i_tag_we,
   input wire logic [3:0] i_tag_idx,
   input wire logic [15:0] i_tag_value,
   input wire logic i_cmd_valid,
   input wire prr_pkg::cmd_t i_cmd,
   output logic o_cmd_ready,
   output prr_pkg::cap_t o_cap,
   output logic [7:0] o_cap_type,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_byte,
   output logic o_rsp_last,
   output logic [7:0] o_rsp_type,
   output logic [7:0] o_rsp_end,
   input wire logic i_rsp_ready
);

   ////////////////////////////////////////////////////////////////////////////////
   // sizes

   function automatic logic [15:0] low_mask(input int n);
      low_mask = 16'((32'h1 << n) - 32'h1);
   endfunction

   localparam int NMAC = UNICAST_CNT + MULTICAST_CNT + MIXED_CNT;
   localparam int RAW_END = int'(`POS_MACS) + `MAC_BYTES * NMAC + `TAG_BYTES * VLAN_CNT;
   // bytes up to the checksum, padded to a whole word
   localparam int END_INT = ((RAW_END + `WORD_BYTES - 1) / `WORD_BYTES) * `WORD_BYTES;
   localparam logic [7:0] END_POS = 8'(END_INT);
   localparam logic [7:0] LAST_POS = 8'(END_INT - 1);
   localparam logic [15:0] MAC_MASK = low_mask(NMAC);
   localparam logic [15:0] TAG_MASK = low_mask(VLAN_CNT);
   localparam logic [3:0] MAC_LAST_ENT = 4'(NMAC - 1);
   localparam logic [3:0] TAG_LAST_ENT = 4'(VLAN_CNT - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // capability fields

   assign o_cap_type = `TYPE_CAPS_RSP;
   assign o_cap.filt_counts = {8'(VLAN_CNT), 8'(MIXED_CNT), 8'(MULTICAST_CNT),
                               8'(UNICAST_CNT)};
   assign o_cap.mode_chan = {16'h0000, 5'h00, ANY_VLAN_PLUS_NON, VLAN_PLUS_NON, 1'b1,
                             8'(CHANNEL_CNT)};

   ////////////////////////////////////////////////////////////////////////////////
   // stored filter entries, index order is unicast, multicast, mixed

   logic mac_re;
   logic tag_re;
   logic [3:0] ent_r;
   logic [3:0] ent_nxt;
   logic [47:0] mac_q;
   logic [15:0] tag_q;

   entry_store #(.WIDTH(48), .DEPTH(NMAC), .AW(3)) u_mac_store (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_we(i_mac_we),
      .i_waddr(i_mac_idx),
      .i_wdata(i_mac_value),
      .i_re(mac_re),
      .i_raddr(ent_r[2:0]),
      .o_rdata(mac_q)
   );

   entry_store #(.WIDTH(16), .DEPTH(VLAN_CNT), .AW(4)) u_tag_store (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_we(i_tag_we),
      .i_waddr(i_tag_idx),
      .i_wdata(i_tag_value),
      .i_re(tag_re),
      .i_raddr(ent_r),
      .o_rdata(tag_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // fixed part, bytes 16 to 47, byte 16 in the top bits

   logic [255:0] fixed_v;
   assign fixed_v = {`RSP_CODE_OK, `REASON_NONE,
                     8'(NMAC), 16'h0000, i_cfg.mac_en & MAC_MASK[7:0],
                     8'(VLAN_CNT), 8'h00, {1'b0, i_cfg.vlan_en} & TAG_MASK,
                     i_cfg.link, i_cfg.bcast,
                     28'h0000000, i_cfg.flags,
                     i_cfg.vlan_mode, i_cfg.flow_ctrl, 16'h0000, i_cfg.aen};

   ////////////////////////////////////////////////////////////////////////////////
   // response sequencer

   prr_pkg::state_t state_r;
   prr_pkg::state_t state_nxt;
   logic [7:0] pos_r;
   logic [7:0] pos_nxt;
   logic [2:0] sub_r;
   logic [2:0] sub_nxt;
   logic [255:0] snap_r;
   logic [255:0] snap_nxt;
   logic out_valid_r;
   logic out_valid_nxt;
   logic [7:0] out_byte_r;
   logic [7:0] out_byte_nxt;
   logic out_last_r;
   logic out_last_nxt;
   logic [7:0] out_pos_r;
   logic [7:0] out_pos_nxt;
   logic adv;
   logic load;
   logic [7:0] nbyte;
   logic take_ok;
   logic [4:0] fix_idx;

   // the output register is the only stage, so it may refill while being taken
   assign adv = !out_valid_r || i_rsp_ready;
   // a query with a bad checksum or wrong identifier is dropped without a word
   assign take_ok = i_cmd_valid && o_cmd_ready && (i_cmd.kind == `TYPE_GET_PARAMS)
                    && !i_cmd.chksum_err && !i_cmd.id_mismatch;
   assign fix_idx = 5'(pos_r - `POS_CODE);

   always_comb
   begin
      state_nxt = state_r;
      pos_nxt = pos_r;
      ent_nxt = ent_r;
      sub_nxt = sub_r;
      snap_nxt = snap_r;
      mac_re = 1'b0;
      tag_re = 1'b0;
      load = 1'b0;
      nbyte = 8'h00;
      case (state_r)
         prr_pkg::ST_IDLE:
         begin
            if (take_ok)
            begin
               state_nxt = prr_pkg::ST_FIXED;
               pos_nxt = `POS_CODE;
               snap_nxt = fixed_v;
            end
         end
         prr_pkg::ST_FIXED:
         begin
            if (adv)
            begin
               load = 1'b1;
               nbyte = 8'(snap_r >> {5'h1F - fix_idx, 3'h0});
               if (pos_r == `POS_MACS - 8'h01)
               begin
                  state_nxt = prr_pkg::ST_MAC_RD;
                  ent_nxt = 4'h0;
               end
            end
         end
         prr_pkg::ST_MAC_RD:
         begin
            mac_re = 1'b1;
            sub_nxt = 3'h0;
            state_nxt = prr_pkg::ST_MAC_OUT;
         end
         prr_pkg::ST_MAC_OUT:
         begin
            if (adv)
            begin
               load = 1'b1;
               nbyte = 8'(mac_q >> {3'(`MAC_LAST_BYTE - sub_r), 3'h0});
               sub_nxt = sub_r + 3'h1;
               if (sub_r == `MAC_LAST_BYTE)
               begin
                  // next address follows after one read cycle, no gap bytes
                  ent_nxt = ent_r + 4'h1;
                  state_nxt = prr_pkg::ST_MAC_RD;
                  if (ent_r == MAC_LAST_ENT)
                  begin
                     ent_nxt = 4'h0;
                     state_nxt = (VLAN_CNT > 0) ? prr_pkg::ST_TAG_RD : prr_pkg::ST_PAD;
                  end
               end
            end
         end
         prr_pkg::ST_TAG_RD:
         begin
            tag_re = 1'b1;
            sub_nxt = 3'h0;
            state_nxt = prr_pkg::ST_TAG_OUT;
         end
         prr_pkg::ST_TAG_OUT:
         begin
            if (adv)
            begin
               load = 1'b1;
               nbyte = 8'(tag_q >> {3'(`TAG_LAST_BYTE - sub_r), 3'h0});
               sub_nxt = sub_r + 3'h1;
               if (sub_r == `TAG_LAST_BYTE)
               begin
                  ent_nxt = ent_r + 4'h1;
                  state_nxt = prr_pkg::ST_TAG_RD;
                  if (ent_r == TAG_LAST_ENT)
                  begin
                     state_nxt = prr_pkg::ST_PAD;
                  end
               end
            end
         end
         prr_pkg::ST_PAD:
         begin
            if (adv)
            begin
               load = 1'b1;
            end
         end
         default:
         begin
            state_nxt = prr_pkg::ST_IDLE;
         end
      endcase
      if (load)
      begin
         pos_nxt = pos_r + 8'h01;
         if (pos_r == LAST_POS)
         begin
            state_nxt = prr_pkg::ST_IDLE;
         end
      end
   end

   always_comb
   begin
      out_valid_nxt = out_valid_r;
      out_byte_nxt = out_byte_r;
      out_last_nxt = out_last_r;
      out_pos_nxt = out_pos_r;
      if (load)
      begin
         out_valid_nxt = 1'b1;
         out_byte_nxt = nbyte;
         out_last_nxt = (pos_r == LAST_POS);
         out_pos_nxt = pos_r;
      end
      else if (i_rsp_ready)
      begin
         out_valid_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_r <= prr_pkg::ST_IDLE;
         pos_r <= 8'h00;
         ent_r <= 4'h0;
         sub_r <= 3'h0;
         snap_r <= '0;
         out_valid_r <= 1'b0;
         out_byte_r <= 8'h00;
         out_last_r <= 1'b0;
         out_pos_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         pos_r <= pos_nxt;
         ent_r <= ent_nxt;
         sub_r <= sub_nxt;
         snap_r <= snap_nxt;
         out_valid_r <= out_valid_nxt;
         out_byte_r <= out_byte_nxt;
         out_last_r <= out_last_nxt;
         out_pos_r <= out_pos_nxt;
      end
   end

   assign o_cmd_ready = (state_r == prr_pkg::ST_IDLE);
   assign o_rsp_valid = out_valid_r;
   assign o_rsp_byte = out_byte_r;
   assign o_rsp_last = out_last_r;
   assign o_rsp_type = `TYPE_PARAMS_RSP;
   assign o_rsp_end = END_POS;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_good_query;
      i_cmd_valid && o_cmd_ready && (i_cmd.kind == `TYPE_GET_PARAMS)
      && !i_cmd.chksum_err && !i_cmd.id_mismatch;
   endsequence

   sequence s_first_byte;
      o_rsp_valid && (out_pos_r == `POS_CODE);
   endsequence

   property p_vlan_count;
      o_cap.filt_counts[31:24] <= 8'(`MAX_VLAN_FILTERS);
   endproperty
   a_vlan_count: assert property (p_vlan_count) else $error("vlan filter count too big");

   property p_unicast_avail;
      (o_cap.filt_counts[7:0] != 8'h00) || (o_cap.filt_counts[23:16] != 8'h00);
   endproperty
   a_unicast_avail: assert property (p_unicast_avail) else $error("no unicast filter");

   property p_filter_sum;
      (10'(o_cap.filt_counts[7:0]) + 10'(o_cap.filt_counts[15:8])
       + 10'(o_cap.filt_counts[23:16])) <= 10'(`MAX_MAC_FILTERS);
   endproperty
   a_filter_sum: assert property (p_filter_sum) else $error("too many mac filters");

   property p_mode_bits;
      o_cap.mode_chan[8] && (o_cap.mode_chan[15:11] == 5'h00);
   endproperty
   a_mode_bits: assert property (p_mode_bits) else $error("vlan mode field wrong");

   property p_answer;
      s_good_query |-> ##[1:3] s_first_byte;
   endproperty
   a_answer: assert property (p_answer) else $error("query not answered");

   property p_drop;
      i_cmd_valid && o_cmd_ready && (i_cmd.chksum_err || i_cmd.id_mismatch)
      |=> o_cmd_ready;
   endproperty
   a_drop: assert property (p_drop) else $error("bad query was taken");

   property p_generic_code;
      o_rsp_valid && (out_pos_r >= `POS_CODE) && (out_pos_r <= `POS_CODE_LAST)
      |-> o_rsp_byte == 8'h00;
   endproperty
   a_generic_code: assert property (p_generic_code) else $error("reason code not generic");

   property p_length;
      o_rsp_valid && o_rsp_last |-> (out_pos_r == LAST_POS) && (out_pos_r[1:0] == 2'b11);
   endproperty
   a_length: assert property (p_length) else $error("response length wrong");

   property p_hold;
      o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte) && $stable(out_pos_r);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");

   property p_type;
      o_rsp_type == `TYPE_PARAMS_RSP && o_cap_type == `TYPE_CAPS_RSP;
   endproperty
   a_type: assert property (p_type) else $error("response type wrong");
endmodule

/* logic/prr_defs.svh */
// Summary of operation
// - VLAN filter count field reports supported VLAN filters, at most 15.
// - At least one unicast or mixed address filter always exists.
// - Unicast plus multicast plus mixed filter counts total 8 or fewer.
// - VLAN mode support bit 0 always 1; bits 3 to 7 read zero.
// - Mode bit 1 set only when VLAN plus non-VLAN filtering exists.
// - Mode bit 2 set only when any-VLAN plus non-VLAN filtering exists.
// - Channel count field reports channels of the whole controller.
// - Parameter query carries command type 0x17.
// - Parameter response carries type 0x97.
// - Query always answered unless checksum error or identifier mismatch.
// - Each response field returns the value last configured.
// - Unsupported parameters return zero.
// - No command-specific reason code; generic codes only.
// - Response length follows supported MAC and VLAN filter counts.
// - MAC addresses sent back to back without padding.
// - MAC order: unicast, then multicast, then mixed, sized by counts.
// - Link settings 28-31, broadcast 32-35, then flags, VLAN mode, AEN.
// - First MAC at byte 48, byte 5 first, crossing word boundaries.
// - Counts and mode fields travel in capabilities response type 0x96.
// - MAC flags: one bit per address, bit 0 is address 1.
// - Config flags: broadcast, channel, network transmit, global multicast.
`ifndef PRR_DEFS_SVH
`define PRR_DEFS_SVH

`define TYPE_GET_PARAMS 8'h17
`define TYPE_PARAMS_RSP 8'h97
`define TYPE_CAPS_RSP 8'h96
`define MAX_VLAN_FILTERS 15
`define MAX_MAC_FILTERS 8
`define RSP_CODE_OK 16'h0000
`define REASON_NONE 16'h0000
`define POS_CODE 8'h10
`define POS_CODE_LAST 8'h13
`define POS_MACS 8'h30
`define MAC_BYTES 6
`define TAG_BYTES 2
`define WORD_BYTES 4
`define MAC_LAST_BYTE 3'h5
`define TAG_LAST_BYTE 3'h1

`endif

/* logic/prr_pkg.sv */
package prr_pkg;

   typedef struct packed {
      logic [7:0] mac_en;
      logic [14:0] vlan_en;
      logic [31:0] link;
      logic [31:0] bcast;
      logic [3:0] flags;
      logic [7:0] vlan_mode;
      logic [7:0] flow_ctrl;
      logic [31:0] aen;
   } cfg_t;

   typedef struct packed {
      logic [7:0] kind;
      logic chksum_err;
      logic id_mismatch;
   } cmd_t;

   typedef struct packed {
      logic [31:0] filt_counts;
      logic [31:0] mode_chan;
   } cap_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FIXED,
      ST_MAC_RD,
      ST_MAC_OUT,
      ST_TAG_RD,
      ST_TAG_OUT,
      ST_PAD
   } state_t;

endpackage
